// ### design/adc_acquisition_conversion_sequencer.sv
// Operation
// (RQ1) Acquisition select zero: go flag starts conversion at once, no acquisition.
// (RQ2) Software waits the acquisition time itself when acquisition select is zero.
// (RQ3) Nonzero acquisition select: keep sampling that many periods, then convert.
// (RQ4) Acquisition codes map to 0,2,4,6,8,12,16,20 conversion-clock periods.
// (RQ5) At conversion end clear go flag, set done flag, resume sampling.
// (RQ6) No visible status for acquisition end or conversion start.
// (RQ7) Every conversion lasts exactly eleven conversion-clock periods.
// (RQ8) Seven clock sources: oscillator /2 to /64, or the RC clock.
// (RQ9) Clock codes: 000 /2, 001 /8, 010 /32, 100 /4, 101 /16, 110 /64, x11 RC.
// (RQ10) RC clock source adds one instruction-cycle delay before the clock runs.
// (RQ11) Software picks the shortest period above about two microseconds.
// (RQ12) Conversion start disconnects the hold capacitor from the input pin.
// (RQ13) RC clock above one megahertz: system sleeps through the conversion.
// (RQ14) Software sizes acquisition with 5 us settling plus temperature term.
// (RQ15) Divider counts system clocks to the ratio; periods count on its tick.
// (RQ16) Reset clears go flag and both selects, abandoning any sequence.
`timescale 1ns/1ps
module adc_acquisition_conversion_sequencer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire adc_seq_pkg::bus_req_s bus_req,
  output logic [adc_seq_pkg::DATA_W-1:0] rd_data,
  input wire logic rc_conv_clock,
  output logic hold_capacitor,
  output logic irq
);
  import adc_seq_pkg::*;

  config_s cfg;
  logic go_flag;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] mask;
  seq_state_e state;
  seq_state_e next_state;
  logic [5:0] div_cnt;
  logic [4:0] period_cnt;
  logic [2:0] wait_cnt;
  logic rc_sync1;
  logic rc_sync2;
  logic rc_prev;

  // Register port decode.
  wire wr_config = bus_req.wr && (bus_req.addr == CONFIG_OFS);
  wire wr_control = bus_req.wr && (bus_req.addr == CONTROL_OFS);
  wire wr_mask = bus_req.wr && (bus_req.addr == MASK_OFS);
  wire rd_status = bus_req.rd && (bus_req.addr == STATUS_OFS);

  // Clock source selection.
  wire rc_selected = (cfg.conv_clock_select[1:0] == 2'b11); // [RQ8] [RQ9]
  wire [5:0] osc_last = div_last(cfg.conv_clock_select); // [RQ9]
  wire [4:0] acq_len = acq_periods(cfg.acq_time_select); // [RQ4]
  wire seq_running = (state == ST_ACQ) || (state == ST_CONV);
  wire rc_edge = rc_sync2 && !rc_prev;
  wire osc_tick = (div_cnt == osc_last);
  wire tick = seq_running && (rc_selected ? rc_edge : osc_tick); // [RQ15]

  // Phase endings.
  wire acq_last = (period_cnt == acq_len - 5'h01);
  wire conv_last = (period_cnt == CONV_PERIODS - 5'h01);
  wire acq_end = (state == ST_ACQ) && tick && acq_last;
  wire conv_end = (state == ST_CONV) && tick && conv_last; // [RQ7]
  wire rc_wait_end = (state == ST_RC_WAIT) &&
    (wait_cnt == INSTR_CYCLE_CLKS - 3'h1);
  wire no_acq = (cfg.acq_time_select == 3'h0);
  wire abort = !go_flag && (state != ST_SAMPLE);

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      ST_SAMPLE: begin
        if (go_flag) begin
          if (rc_selected) begin
            next_state = ST_RC_WAIT; // [RQ10]
          end else if (no_acq) begin
            next_state = ST_CONV; // [RQ1]
          end else begin
            next_state = ST_ACQ; // [RQ3]
          end
        end
      end
      ST_RC_WAIT: begin
        if (rc_wait_end) begin
          next_state = no_acq ? ST_CONV : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (acq_end) begin
          next_state = ST_CONV; // [RQ3]
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          next_state = ST_SAMPLE; // [RQ5]
        end
      end
      default: begin
        next_state = ST_SAMPLE;
      end
    endcase
    if (abort) begin
      next_state = ST_SAMPLE;
    end
  end

  // Clearing the go flag mid-sequence aborts it, as software expects.
  wire phase_change = (next_state != state);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SAMPLE; // [RQ16]
    end else begin
      state <= next_state;
    end
  end

  // The hold switch follows the next state so it opens on the same edge
  // that the conversion begins.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_capacitor <= 1'b1;
    end else begin
      hold_capacitor <= (next_state != ST_CONV); // [RQ12]
    end
  end

  // Divider restarts on every phase change so each phase gets whole periods.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 6'h00;
    end else if (phase_change || !seq_running || osc_tick) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01; // [RQ15]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= 5'h00;
    end else if (phase_change) begin
      period_cnt <= 5'h00;
    end else if (tick) begin
      period_cnt <= period_cnt + 5'h01; // [RQ15]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 3'h0;
    end else if (state == ST_RC_WAIT) begin
      wait_cnt <= wait_cnt + 3'h1; // [RQ10]
    end else begin
      wait_cnt <= 3'h0;
    end
  end

  // The RC clock is unrelated to sys_clk, so it is synchronised first.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_sync1 <= 1'b0;
      rc_sync2 <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      rc_sync1 <= rc_conv_clock;
      rc_sync2 <= rc_sync1;
      rc_prev <= rc_sync2;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.acq_time_select <= ACQ_SEL_RST; // [RQ16]
      cfg.conv_clock_select <= CLK_SEL_RST; // [RQ16]
    end else if (wr_config) begin
      cfg.acq_time_select <= bus_req.wdata[ACQ_SEL_LSB +: 3];
      cfg.conv_clock_select <= bus_req.wdata[CLK_SEL_LSB +: 3];
    end
  end

  // Completion clears the flag even if software writes it that same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_flag <= 1'b0; // [RQ16]
    end else if (conv_end) begin
      go_flag <= 1'b0; // [RQ5]
    end else if (wr_control) begin
      go_flag <= bus_req.wdata[GO_BIT];
    end
  end

  // A completion in the cycle of a clearing read stays set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= STATUS_RST;
    end else begin
      status[DONE_BIT] <= conv_end || (status[DONE_BIT] && !rd_status); // [RQ5]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RST;
    end else if (wr_mask) begin
      mask <= bus_req.wdata;
    end
  end

  wire [DATA_W-1:0] next_status = {{(DATA_W-1){1'b0}},
    conv_end || (status[DONE_BIT] && !rd_status)};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end

  // Of the sequence status, only the go flag and the done flag are visible to software.
  wire [DATA_W-1:0] config_view = {2'b00, cfg.acq_time_select,
    cfg.conv_clock_select};
  wire [DATA_W-1:0] control_view = {{(DATA_W-1){1'b0}}, go_flag}; // [RQ6]
  wire [DATA_W-1:0] rd_mux =
    (bus_req.addr == CONFIG_OFS) ? config_view :
    (bus_req.addr == CONTROL_OFS) ? control_view :
    (bus_req.addr == STATUS_OFS) ? status :
    (bus_req.addr == MASK_OFS) ? mask : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // Helper: conversion-clock ticks seen in the current conversion.
  logic [4:0] conv_ticks;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ticks <= 5'h00;
    end else if (state != ST_CONV) begin
      conv_ticks <= 5'h00;
    end else if (tick) begin
      conv_ticks <= conv_ticks + 5'h01;
    end
  end

  // Helper: conversion-clock ticks seen in the current acquisition.
  logic [4:0] acq_ticks;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_ticks <= 5'h00;
    end else if (state != ST_ACQ) begin
      acq_ticks <= 5'h00;
    end else if (tick) begin
      acq_ticks <= acq_ticks + 5'h01;
    end
  end

  go_no_acq_a: assert property ( // [RQ1]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ST_SAMPLE && go_flag && no_acq && !rc_selected)
    |=> (state == ST_CONV) && !hold_capacitor)
    else $error("Go with no acquisition did not start conversion.");

  acq_start_a: assert property ( // [RQ3]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ST_SAMPLE && go_flag && !no_acq && !rc_selected)
    |=> (state == ST_ACQ) && hold_capacitor)
    else $error("Programmed acquisition did not begin with sampling.");

  acq_length_a: assert property ( // [RQ4]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ST_ACQ && next_state == ST_CONV)
    |-> tick && (acq_ticks == acq_len - 5'h01))
    else $error("Acquisition length differs from the selected code.");

  acq_hold_a: assert property ( // [RQ3]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ST_ACQ && go_flag && tick && acq_ticks < acq_len - 5'h01)
    |=> (state == ST_ACQ) && hold_capacitor)
    else $error("Acquisition ended before its programmed length.");

  done_effects_a: assert property ( // [RQ5]
    @(posedge sys_clk) disable iff (!rst_n)
    conv_end |=> !go_flag && status[DONE_BIT] && hold_capacitor
      && (state == ST_SAMPLE))
    else $error("Completion did not clear go, set done and resample.");

  conv_eleven_a: assert property ( // [RQ7]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ST_CONV && $past(state) == ST_CONV && go_flag
      && $past(go_flag) && next_state == ST_SAMPLE)
    |-> (conv_ticks == 5'h0a) && tick)
    else $error("Conversion did not last eleven periods.");

  div_ratio_a: assert property ( // [RQ9]
    @(posedge sys_clk) disable iff (!rst_n)
    (tick && !rc_selected) |-> (div_cnt == osc_last) && !$past(phase_change))
    else $error("Oscillator tick does not match the divide ratio.");

  rc_delay_a: assert property ( // [RQ10]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ST_SAMPLE && go_flag && rc_selected)
    ##1 (go_flag && rc_selected) [*4]
    |-> (state == ST_RC_WAIT) ##1 (state != ST_RC_WAIT))
    else $error("RC start delay is not one instruction cycle.");

  hold_open_a: assert property ( // [RQ12]
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(state == ST_CONV) |-> !hold_capacitor && $past(hold_capacitor))
    else $error("Hold capacitor still connected during conversion.");

  irq_level_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> (irq == |(status & $past(mask))))
    else $error("Interrupt output does not follow status and mask.");

  done_irq_a: assert property ( // [RQ5]
    @(posedge sys_clk) disable iff (!rst_n)
    (conv_end && mask[DONE_BIT]) |=> irq)
    else $error("Unmasked completion did not raise the interrupt.");

  status_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (rd_status && !conv_end) |=> !status[DONE_BIT])
    else $error("Status read did not clear the done flag.");

  hold_conv_a: assert property ( // [RQ12]
    @(posedge sys_clk) disable iff (!rst_n)
    hold_capacitor == (state != ST_CONV))
    else $error("Hold switch does not match the conversion phase.");

  rd_idle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !$past(bus_req.rd) |-> (rd_data == 8'h00))
    else $error("Read data not zero outside the read answer cycle.");

  abort_resample_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state != ST_SAMPLE && !go_flag)
    |=> (state == ST_SAMPLE) && hold_capacitor)
    else $error("Cleared go flag did not abort back to sampling.");

endmodule : adc_acquisition_conversion_sequencer

// ### design/adc_seq_pkg.sv
package adc_seq_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h2;
  localparam logic [ADDR_W-1:0] MASK_OFS = 3'h3;

  // Field positions.
  localparam int ACQ_SEL_LSB = 3;
  localparam int CLK_SEL_LSB = 0;
  localparam int GO_BIT = 0;
  localparam int DONE_BIT = 0;

  // Reset values.
  localparam logic [2:0] ACQ_SEL_RST = 3'h0;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;

  // Timing counts, in conversion-clock periods or system clocks.
  localparam logic [4:0] CONV_PERIODS = 5'h0b;
  localparam logic [2:0] INSTR_CYCLE_CLKS = 3'h4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [2:0] acq_time_select;
    logic [2:0] conv_clock_select;
  } config_s;

  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_RC_WAIT,
    ST_ACQ,
    ST_CONV
  } seq_state_e;

  // Acquisition length in conversion-clock periods.
  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    case (sel)
      3'h0: acq_periods = 5'h00;
      3'h1: acq_periods = 5'h02;
      3'h2: acq_periods = 5'h04;
      3'h3: acq_periods = 5'h06;
      3'h4: acq_periods = 5'h08;
      3'h5: acq_periods = 5'h0c;
      3'h6: acq_periods = 5'h10;
      default: acq_periods = 5'h14;
    endcase
  endfunction : acq_periods

  // Last count of the oscillator divider, one less than the ratio.
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0: div_last = 6'h01;
      3'h1: div_last = 6'h07;
      3'h2: div_last = 6'h1f;
      3'h4: div_last = 6'h03;
      3'h5: div_last = 6'h0f;
      3'h6: div_last = 6'h3f;
      default: div_last = 6'h00;
    endcase
  endfunction : div_last

endpackage : adc_seq_pkg

// ### tb/rc_clock_model.sv
`timescale 1ns/1ps
module rc_clock_model #(
  parameter real HALF_NS = 42.0
) (
  input wire logic run,
  output logic rc_conv_clock
);
  // The RC source is gated by run, so it stands still low while run is low.
  // A period of 84 ns keeps its edges drifting against the 8 ns clock.
  initial begin
    rc_conv_clock = 1'b0;
    forever begin
      #(HALF_NS);
      rc_conv_clock = run ? ~rc_conv_clock : 1'b0;
    end
  end
endmodule : rc_clock_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import adc_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_s bus_req = '0;
  logic [DATA_W-1:0] rd_data;
  logic hold_capacitor;
  logic irq;
  logic run = 1'b0;
  logic rc_conv_clock;
  logic rd_prev = 1'b0;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  int fails = 0;
  int comparisons = 0;
  int seed = 76;
  int n, m, c, r, off;
  int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int div_tab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int clk_codes[6] = '{0, 1, 2, 4, 5, 6};

  always #4 sys_clk = ~sys_clk;

  adc_acquisition_conversion_sequencer u_adc_acquisition_conversion_sequencer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .rc_conv_clock(rc_conv_clock),
    .hold_capacitor(hold_capacitor),
    .irq(irq)
  );

  rc_clock_model u_rc_clock_model (
    .run(run),
    .rc_conv_clock(rc_conv_clock)
  );

  task automatic check(input string name, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // A gap cycle follows each strobe so no strobe is assigned twice at once.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] d);
    exp_q.push_back({a, d});
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  // Read data stand only in the cycle after the strobe, so look mid-cycle.
  always @(negedge sys_clk) begin
    if (rd_prev && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check($sformatf("reg%0d", e[10:8]), rd_data, e[7:0]);
    end
    rd_prev = bus_req.rd;
  end

  task automatic wait_hold(input logic lvl, output int cnt);
    cnt = 0;
    // Step past the edge so the value read is the one that edge launched.
    #1;
    while (hold_capacitor !== lvl) begin
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > 3000) begin
        fails++;
        $display("[FAIL] hold_wait expected %0d seen timeout", lvl);
        stop_test();
      end
    end
  endtask : wait_hold

  task automatic run_conv(input int a, k, flo, fhi, clo, chi, input logic ie);
    wr(CONFIG_OFS, 8'((a << ACQ_SEL_LSB) | k));
    rd(CONFIG_OFS, 8'((a << ACQ_SEL_LSB) | k));
    // With no programmed acquisition the bench waits it out itself.
    if (a == 0) repeat (16) @(posedge sys_clk);
    wr(CONTROL_OFS, 8'h01);
    wait_hold(1'b0, n);
    check("acq_len", 8'(n >= flo && n <= fhi), 8'h01);
    wait_hold(1'b1, m);
    check("conv_len", 8'(m >= clo && m <= chi), 8'h01);
    check("irq_set", 8'(irq), 8'(ie));
    @(posedge sys_clk);
    rd(CONTROL_OFS, 8'h00);
    rd(STATUS_OFS, 8'h01);
    rd(STATUS_OFS, 8'h00);
    #1;
    check("irq_clr", 8'(irq), 8'h00);
    @(posedge sys_clk);
    $display("conversion acq %0d clk %0d done", a, k);
  endtask : run_conv

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int a = 0; a < 5; a++) rd(3'(a), 8'h00);
    $display("reset values done");
    wr(MASK_OFS, 8'h01);
    // A random start offset walks all six divider codes in eight runs.
    off = $unsigned($random(seed)) % 6;
    for (int a = 0; a < 8; a++) begin
      c = clk_codes[(a + off) % 6];
      r = div_tab[c];
      run_conv(a, c, acq_tab[a] * r, acq_tab[a] * r, 11 * r, 11 * r,
               1'b1);
    end
    // The RC runs use a cleared mask, so irq must stay low.
    wr(MASK_OFS, 8'h00);
    // The bench stays off the bus during RC conversions, like a sleeping core.
    run <= 1'b1;
    run_conv(0, 3, 4, 6, 104, 127, 1'b0);
    // RC edges pass two flops and an edge detector, so two periods plus the
    // four-cycle wait end 15 to 26 clocks after the go flag is taken.
    run_conv(1, 7, 15, 26, 104, 127, 1'b0);
    run <= 1'b0;
    // Abort in mid-conversion returns to sampling without completion.
    wr(CONFIG_OFS, 8'h06);
    wr(CONTROL_OFS, 8'h01);
    wait_hold(1'b0, n);
    repeat (20) @(posedge sys_clk);
    wr(CONTROL_OFS, 8'h00);
    #1;
    check("abort_hold", 8'(hold_capacitor), 8'h01);
    @(posedge sys_clk);
    rd(STATUS_OFS, 8'h00);
    $display("abort done");
    wr(CONTROL_OFS, 8'h01);
    wait_hold(1'b0, n);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("reset_hold", 8'(hold_capacitor), 8'h01);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(CONFIG_OFS, 8'h00);
    rd(CONTROL_OFS, 8'h00);
    $display("mid-run reset done");
    stop_test();
  end
endmodule : testbench
